// >>> hw/ddr_burst_sram_port.sv
// Double-data-rate four-word burst SRAM port, oversampling both timing inputs

`timescale 1ns/100ps
`default_nettype none

module ddr_burst_sram_port
    import ddr_sram_pkg::*;
(
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic k_in, // True timing input
    input wire logic k_n_in, // Complementary timing input
    input wire logic [ADDR_W-1:0] addr_in, // Burst address
    input wire logic fetch_port_select_n, // Read port select, active low
    input wire logic store_port_select_n, // Write port select, active low
    input wire logic [LANES-1:0] byte_lane_select_n, // Byte write selects, active low
    input wire logic [NIBS-1:0] nibble_lane_select_n, // Nibble write selects, active low
    input wire logic [1:0] width_cfg, // Width strap: x8, x9, x18, x36
    input wire logic [WORD_W-1:0] d_in, // Write data
    output logic [WORD_W-1:0] q_out, // Read data
    output logic q_oe // Read data drive enable
);
    pins_t pin_raw;
    pins_t sync1_ff;
    pins_t sync2_ff;
    logic k_prev_ff;
    logic kn_prev_ff;
    logic rd_prev_ff;
    logic wr_prev_ff;
    slot_t rd1_ff, rd2_ff, rd3_ff, rd4_ff;
    slot_t wr1_ff, wr2_ff, wr3_ff;
    logic [WORD_W-1:0] q_ff;
    logic oe_ff;

    // Pin bundle ahead of the two-stage synchroniser
    assign pin_raw.k = k_in;
    assign pin_raw.k_n = k_n_in;
    assign pin_raw.fetch_n = fetch_port_select_n;
    assign pin_raw.store_n = store_port_select_n;
    assign pin_raw.lane_n = byte_lane_select_n;
    assign pin_raw.nib_n = nibble_lane_select_n;
    assign pin_raw.cfg = width_cfg_t'(width_cfg);
    assign pin_raw.addr = addr_in;
    assign pin_raw.d = d_in;

    // Two flops before any logic; reset to parked levels so no false edge follows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_ff <= PIN_IDLE;
            sync2_ff <= PIN_IDLE;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    // Rising edges of both timing inputs; a stopped clock gives none
    wire k_rise = sync2_ff.k & ~k_prev_ff;
    wire kn_rise = sync2_ff.k_n & ~kn_prev_ff;

    // Starts need select low now and high at the previous K rise
    wire start_rd = k_rise & ~sync2_ff.fetch_n & rd_prev_ff;
    wire start_wr = k_rise & ~sync2_ff.store_n & wr_prev_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            k_prev_ff <= PIN_IDLE.k;
            kn_prev_ff <= PIN_IDLE.k_n;
        end else begin
            k_prev_ff <= sync2_ff.k;
            kn_prev_ff <= sync2_ff.k_n;
        end
    end

    // Selects remembered only at K rise; reset as deselected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_prev_ff <= SEL_IDLE;
            wr_prev_ff <= SEL_IDLE;
        end else if (k_rise) begin
            rd_prev_ff <= sync2_ff.fetch_n;
            wr_prev_ff <= sync2_ff.store_n;
        end
    end

    // Burst age pipelines, advanced once per K cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd1_ff <= '0;
            rd2_ff <= '0;
            rd3_ff <= '0;
            rd4_ff <= '0;
            wr1_ff <= '0;
            wr2_ff <= '0;
            wr3_ff <= '0;
        end else if (k_rise) begin
            rd1_ff <= '{vld: start_rd, addr: sync2_ff.addr};
            rd2_ff <= rd1_ff;
            rd3_ff <= rd2_ff;
            rd4_ff <= rd3_ff;
            wr1_ff <= '{vld: start_wr, addr: sync2_ff.addr};
            wr2_ff <= wr1_ff;
            wr3_ff <= wr2_ff;
        end
    end

    // Write word select: K rise takes A or A+2, K# rise takes A+1 or A+3
    wire [ADDR_W-1:0] wr_base = k_rise ? (wr1_ff.vld ? wr1_ff.addr : wr2_ff.addr)
                                       : (wr2_ff.vld ? wr2_ff.addr : wr3_ff.addr);
    wire [IDX_W-1:0] wr_idx = k_rise ? (wr1_ff.vld ? IDX_W0 : IDX_W2)
                                     : (wr2_ff.vld ? IDX_W1 : IDX_W3);
    wire wr_any = k_rise ? (wr1_ff.vld | wr2_ff.vld) : (wr2_ff.vld | wr3_ff.vld);
    wire wr_go = (k_rise | kn_rise) & wr_any;

    // Read word select: two cycles after the address
    wire [ADDR_W-1:0] rd_base = k_rise ? (rd2_ff.vld ? rd2_ff.addr : rd3_ff.addr)
                                       : (rd3_ff.vld ? rd3_ff.addr : rd4_ff.addr);
    wire [IDX_W-1:0] rd_idx = k_rise ? (rd2_ff.vld ? IDX_W0 : IDX_W2)
                                     : (rd3_ff.vld ? IDX_W1 : IDX_W3);
    wire rd_any = k_rise ? (rd2_ff.vld | rd3_ff.vld) : (rd3_ff.vld | rd4_ff.vld);
    wire rd_go = (k_rise | kn_rise) & rd_any;

    // Per-bit write enables from this word's own selects
    logic [WORD_W-1:0] bit_we;
    genvar i;
    generate
        for (i = 0; i < WORD_W; i = i + 1) begin : g_lane
            wire en_x8;
            wire en_x9;
            wire en_x18;
            wire en_x36 = ~sync2_ff.lane_n[i / LANE_BITS];
            if (i < X8_BITS) begin : g_x8
                assign en_x8 = ~sync2_ff.nib_n[i / NIB_BITS];
            end else begin : g_x8_off
                assign en_x8 = 1'h0;
            end
            if (i < X9_BITS) begin : g_x9
                assign en_x9 = ~sync2_ff.lane_n[0];
            end else begin : g_x9_off
                assign en_x9 = 1'h0;
            end
            if (i < X18_BITS) begin : g_x18
                assign en_x18 = ~sync2_ff.lane_n[i / LANE_BITS];
            end else begin : g_x18_off
                assign en_x18 = 1'h0;
            end
            assign bit_we[i] = (sync2_ff.cfg == CFG_X8) ? en_x8 :
                               (sync2_ff.cfg == CFG_X9) ? en_x9 :
                               (sync2_ff.cfg == CFG_X18) ? en_x18 : en_x36;
        end
    endgenerate

    // All selects high leaves the mask empty
    wire [WORD_W-1:0] wr_mask = bit_we & {WORD_W{wr_go}};

    logic [WORD_W-1:0] rd_word;

    ddr_sram_array u_array (
        .clk_sys(clk_sys),
        .wr_en(wr_go),
        .wr_addr({wr_base, wr_idx}),
        .wr_mask(wr_mask),
        .wr_data(sync2_ff.d),
        .rd_addr({rd_base, rd_idx}),
        .rd_data(rd_word)
    );

    // Read output register; drive drops at the first K rise with no word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
            oe_ff <= 1'h0;
        end else if (rd_go) begin
            q_ff <= rd_word;
            oe_ff <= 1'h1;
        end else if (k_rise) begin
            oe_ff <= 1'h0;
        end
    end

    assign q_out = q_ff;
    assign q_oe = oe_ff;
endmodule : ddr_burst_sram_port

`default_nettype wire

// >>> hw/ddr_sram_array.sv
// Package for the burst SRAM port and the bit-maskable storage array
package ddr_sram_pkg;
    localparam int WORD_W = 36;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 2;
    localparam int LANES = 4;
    localparam int NIBS = 2;
    localparam int LANE_BITS = 9;
    localparam int NIB_BITS = 4;
    localparam int X8_BITS = 8;
    localparam int X9_BITS = 9;
    localparam int X18_BITS = 18;
    localparam int DEPTH = 1 << (ADDR_W + IDX_W);
    // Burst word positions: A, A+1, A+2, A+3
    localparam logic [IDX_W-1:0] IDX_W0 = 2'h0;
    localparam logic [IDX_W-1:0] IDX_W1 = 2'h1;
    localparam logic [IDX_W-1:0] IDX_W2 = 2'h2;
    localparam logic [IDX_W-1:0] IDX_W3 = 2'h3;
    // Deselected level of a port select after reset
    localparam logic SEL_IDLE = 1'h1;

    typedef enum logic [1:0] {
        CFG_X8 = 2'h0,
        CFG_X9 = 2'h1,
        CFG_X18 = 2'h2,
        CFG_X36 = 2'h3
    } width_cfg_t;

    // All pins as one sampled bundle
    typedef struct packed {
        logic k;
        logic k_n;
        logic fetch_n;
        logic store_n;
        logic [LANES-1:0] lane_n;
        logic [NIBS-1:0] nib_n;
        width_cfg_t cfg;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] d;
    } pins_t;

    // Parked pin levels: timing inputs and port selects high, rest low
    localparam pins_t PIN_IDLE = pins_t'({4'hF, 52'h0});

    // One burst in flight
    typedef struct packed {
        logic vld;
        logic [ADDR_W-1:0] addr;
    } slot_t;
endpackage : ddr_sram_pkg

`timescale 1ns/100ps
`default_nettype none

module ddr_sram_array
    import ddr_sram_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic wr_en, // Write strobe
    input wire logic [ADDR_W+IDX_W-1:0] wr_addr, // Write word index
    input wire logic [WORD_W-1:0] wr_mask, // Per-bit write enable
    input wire logic [WORD_W-1:0] wr_data, // Write word
    input wire logic [ADDR_W+IDX_W-1:0] rd_addr, // Read word index
    output logic [WORD_W-1:0] rd_data // Read word, combinational
);
    logic [WORD_W-1:0] mem [DEPTH];

    // Unselected bits keep their stored value
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    assign rd_data = mem[rd_addr];
endmodule : ddr_sram_array

`default_nettype wire

// >>> test/ddr_burst_sram_port_tb.sv
// Self-checking bench for the burst SRAM port
`timescale 1ns/100ps
`default_nettype none

module ddr_burst_sram_port_tb
    import ddr_sram_pkg::*;
;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [WORD_W-1:0] q_out;
    logic q_oe;
    pins_t p;
    logic [WORD_W-1:0] mem [DEPTH];
    int fail_count = 0;
    int n_compared = 0;
    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    host_ctl_model host (.clk_sys(clk_sys), .p(p));
    ddr_burst_sram_port uut (.clk_sys(clk_sys), .rst(rst), .k_in(p.k), .k_n_in(p.k_n),
        .addr_in(p.addr), .fetch_port_select_n(p.fetch_n), .store_port_select_n(p.store_n),
        .byte_lane_select_n(p.lane_n), .nibble_lane_select_n(p.nib_n), .width_cfg(p.cfg),
        .d_in(p.d), .q_out(q_out), .q_oe(q_oe));
    // Bits a word writes for a width and its selects
    function automatic logic [WORD_W-1:0] lmask(width_cfg_t c, logic [3:0] b, logic [1:0] n);
        case (c)
            CFG_X8: return {28'h0, {4{~n[1]}}, {4{~n[0]}}};
            CFG_X9: return {27'h0, {9{~b[0]}}};
            CFG_X18: return {18'h0, {9{~b[1]}}, {9{~b[0]}}};
            default: return {{9{~b[3]}}, {9{~b[2]}}, {9{~b[1]}}, {9{~b[0]}}};
        endcase
    endfunction : lmask
    task automatic chk(input string nm, input logic [WORD_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Prep, five timing cycles, then park
    task automatic op(input logic rd, wr, dbl, full, width_cfg_t c, logic [ADDR_W-1:0] a);
        pins_t v;
        logic s;
        logic [WORD_W-1:0] m;
        v = host.p;
        v.cfg = c;
        for (int h = -1; h < 11; h++) begin
            s = h == 0 || (h == 2 && dbl);
            v.k = h == 10 || (h >= 0 && !h[0]);
            v.k_n = h[0] || h == 10;
            v.fetch_n = h[0] && h > 0 ? 1'($urandom) : !(rd && s);
            v.store_n = h[0] && h > 0 ? 1'($urandom) : !(wr && s);
            v.addr = h == 0 ? a : ADDR_W'($urandom);
            v.d = WORD_W'({$urandom, $urandom});
            v.lane_n = full ? 4'h0 : 4'($urandom);
            v.nib_n = full ? 2'h0 : 2'($urandom);
            if (wr && h > 1 && h < 6) begin
                m = lmask(c, v.lane_n, v.nib_n);
                mem[{a, 2'(h - 2)}] = (mem[{a, 2'(h - 2)}] & ~m) | (v.d & m);
            end
            host.step(v);
            chk("q_oe", WORD_W'(q_oe), WORD_W'(rd && h > 3 && h < 8));
            m = lmask(c, 4'h0, 2'h0);
            if (rd && h > 3 && h < 8) chk("q_out", q_out & m, mem[{a, 2'(h - 4)}] & m);
        end
    endtask : op
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Main sequence: per width, full write, masked write, read, both at once
    initial begin
        logic [ADDR_W-1:0] a;
        void'($urandom(32'h4F89387F));
        repeat (5) @(posedge clk_sys);
        #1 chk("q_oe", WORD_W'(q_oe), '0);
        rst = 1'h0;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 3; r++) begin
                a = ADDR_W'($urandom);
                op(0, 1, 0, 1, width_cfg_t'(c), a);
                op(0, 1, r[0], 0, width_cfg_t'(c), a);
                op(1, 0, r[1], 0, width_cfg_t'(c), a);
                op(1, 1, 0, 0, width_cfg_t'(c), a);
            end
        end
        print_verdict();
    end
    // Watchdog against a hung run
    initial begin
        #2000000;
        fail_count++;
        print_verdict();
    end
endmodule : ddr_burst_sram_port_tb
`default_nettype wire

// >>> test/ddr_sram_monitor.sv
// Checker on the read side of the port
`timescale 1ns/100ps
`default_nettype none

module ddr_sram_monitor
    import ddr_sram_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic k_in, // True timing
    input wire logic k_n_in, // Complement timing
    input wire logic fetch_port_select_n, // Read select
    input wire logic [WORD_W-1:0] q_out, // Read data
    input wire logic q_oe // Drive enable
);
    logic k_ff, kn_ff, fprev_ff;
    logic [2:0] krc_ff;
    wire kr = k_in & ~k_ff; // K rise
    wire knr = k_n_in & ~kn_ff; // K# rise
    wire kev = kr | knr; // Any timing rise
    wire rds = kr & ~fetch_port_select_n & fprev_ff; // Read start
    wire [2:0] nxt_krc = rds ? 3'h0 : krc_ff + {2'h0, krc_ff != 3'h7};
    // Timing pin history
    always_ff @(posedge clk_sys) begin
        k_ff <= k_in;
        kn_ff <= k_n_in;
    end
    // K rises since the last read start
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fprev_ff <= SEL_IDLE;
            krc_ff <= 3'h7;
        end else if (kr) begin
            fprev_ff <= fetch_port_select_n;
            krc_ff <= nxt_krc;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_after_k;
        $past(kr, 3) || $past(kr, 4) || $past(kr, 5);
    endsequence
    a_reset_quiet: assert property ($fell(rst) |-> !q_oe && q_out == '0)
        else $error("outputs busy after reset");
    a_oe_rise_lat: assert property ($rose(q_oe) |-> krc_ff == 3'h2)
        else $error("read data latency wrong");
    a_oe_rise_k: assert property ($rose(q_oe) |-> s_after_k)
        else $error("read drive not on K rise");
    a_oe_fall_cnt: assert property ($fell(q_oe) |-> krc_ff == 3'h4)
        else $error("read burst length wrong");
    a_oe_fall_k: assert property ($fell(q_oe) |-> s_after_k)
        else $error("drive release not on K rise");
    a_oe_hold: assert property ($rose(q_oe) |=> q_oe [*8])
        else $error("read burst cut short");
    a_q_edge: assert property (!$stable(q_out) |-> $past(kev, 4) || $past(kev, 3))
        else $error("read data moved off an edge");
    a_q_hold: assert property (!q_oe && !$past(q_oe) |-> $stable(q_out))
        else $error("idle read data moved");
endmodule : ddr_sram_monitor

bind ddr_burst_sram_port ddr_sram_monitor mon (.clk_sys, .rst, .k_in, .k_n_in,
    .fetch_port_select_n, .q_out, .q_oe);
`default_nettype wire

// >>> test/host_ctl_model.sv
// Host controller model driving the port pins
`timescale 1ns/100ps
`default_nettype none

module host_ctl_model
    import ddr_sram_pkg::*;
(
    input wire logic clk_sys, // Clock
    output var pins_t p // Pins to port
);
    // Parked with both timing inputs high
    initial p = pins_t'(56'hF0000000000000);

    // Pins change together and hold five clocks
    task automatic step(input pins_t v); // Half period
        @(posedge clk_sys);
        #1 p = v;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : step
endmodule : host_ctl_model
`default_nettype wire
